// *** fsc_unit.sv ***
// Float unit gating, register file, load/store conversion and status word
//
// How it works
// - With float_available high, issued float instructions execute normally.
// - With float_available low, execution is suppressed and unavailable irq pulses.
// - Exceptions set status bits; precise interrupt only when enabled.
// - Detects invalid (six subclasses), zero divide, overflow, underflow, inexact.
// - Each exception and invalid subclass has its own sticky status bit.
// - Each exception class has an enable bit in the status word.
// - float_trap_enable allows a precise program interrupt on enabled exceptions.
// - Thirty-two float registers selected by 5-bit fields.
// - Each register is 64 bits, interpreted as double format.
// - Arith and round ops write a register and record status; compare records status and condition flags.
// - Double loads and stores move 64 bits unchanged.
// - Single loads convert single format to the same double value.
// - Single stores convert double register value to single, truncating the dropped low fraction bits.
// - Status word: bits 0-19 status, 20-31 control, 20-23 and 29 reserved.
// - Bits 3-6 record overflow, underflow, zero divide, inexact.
// - Bits 7-12 record the six invalid subclasses in order.
// - Bit 13 rounded, bit 14 inexact fraction, bit 15 result class.
// - Bits 16-19 hold less, greater, equal, unordered compare flags.
// - Bits 24-28 enable invalid, overflow, underflow, zero divide, inexact.
// - Bits 30-31 are the rounding control field.
// - Bit 0 set when an arith/compare/round op turns any exception bit on.
// - Bit 1 is OR of exception bits masked by their enables.
// - Bit 2 is OR of all invalid subclass bits.
//
// Implementation choices: the register addresses and the APB interface to the registers.
`include "fsc_params.svh"
`default_nettype none

module fsc_unit
    import fsc_pkg::*;
#(
    parameter int REG_COUNT = 32,
    parameter int REG_WIDTH = 64
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    // Machine state bits
    input wire logic floatAvailable,
    input wire logic floatTrapEnable,
    // Instruction issue from dispatch
    input wire fsc_issue_t issue,
    output logic issueReady,
    // Results toward the core
    output logic issueDone,
    output logic [REG_WIDTH-1:0] operandA,
    output logic [REG_WIDTH-1:0] operandB,
    output fsc_store_t store,
    output logic [3:0] condField,
    output logic [1:0] roundMode,
    output logic unavailableIrq,
    output logic programIrq,
    // APB register port
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    logic [REG_WIDTH-1:0] floatReg [REG_COUNT];
    logic [31:0] statusStore;
    logic [31:0] statusWord;
    logic [31:0] next_status;
    logic [31:0] excSetMask;
    logic [31:0] excBits;
    logic [31:0] enabledBits;
    logic anyEnabled;
    logic take;
    logic runOp;
    logic statusOp;
    logic apbWrite;
    logic apbHit;
    logic [63:0] loadSingle;
    logic [31:0] storeSingle;

    // Single to double: denormals are normalised since double has the range
    function automatic logic [63:0] single_to_double(input logic [31:0] s);
        logic [10:0] e;
        logic [22:0] f;
        int lead;
        e = '0;
        f = s[22:0];
        lead = 0;
        if (s[30:23] == `FSC_SGL_EXP_MAX) begin
            e = `FSC_DBL_EXP_MAX;
        end else if (s[30:23] != 8'h00) begin
            e = {3'h0, s[30:23]} + `FSC_SGL_BIAS_ADJ;
        end else if (f != 23'h000000) begin
            for (int i = 0; i < 23; i++) begin
                if (f[i]) begin
                    lead = i;
                end
            end
            e = `FSC_SGL_BIAS_ADJ + 11'(lead) - 11'd22;
            f = 23'(f << (23 - lead));
        end
        return {s[31], e, f, 29'h0};
    endfunction

    // Double to single: values in single range map exactly apart from the
    // dropped low fraction bits, which are truncated
    function automatic logic [31:0] double_to_single(input logic [63:0] d);
        logic [10:0] e;
        logic [23:0] m;
        logic [7:0] se;
        int sh;
        e = d[62:52];
        se = '0;
        m = {1'b1, d[51:29]};
        sh = 0;
        if (e == `FSC_DBL_EXP_MAX) begin
            se = `FSC_SGL_EXP_MAX;
            m = {1'b0, d[51:29]};
        end else if (e > `FSC_SGL_BIAS_ADJ) begin
            se = 8'(e - `FSC_SGL_BIAS_ADJ);
            m = {1'b0, d[51:29]};
        end else begin
            sh = int'(`FSC_SGL_BIAS_ADJ) + 1 - int'(e);
            m = (sh > 24) ? 24'h000000 : 24'(m >> sh);
        end
        return {d[63], se, m[22:0]};
    endfunction

    assign loadSingle = single_to_double(issue.data[31:0]);
    assign storeSingle = double_to_single(floatReg[issue.srcA]);

    // The unit finishes every op in one cycle, so it never back-pressures
    assign issueReady = 1'b1;
    assign take = ce && issue.valid;
    assign runOp = take && floatAvailable;
    assign statusOp = runOp && (issue.op == FSC_OP_ARITH
        || issue.op == FSC_OP_COMPARE || issue.op == FSC_OP_ROUND_SINGLE);

    // Exception bits raised by this op, placed at their status positions
    always_comb begin
        excSetMask = '0;
        if (statusOp) begin
            excSetMask[`FSC_BIT_OVERFLOW] = issue.exc.overflowBit;
            excSetMask[`FSC_BIT_UNDERFLOW] = issue.exc.underflowBit;
            excSetMask[`FSC_BIT_ZERO_DIV] = issue.exc.zeroDivideBit;
            excSetMask[`FSC_BIT_INEXACT] = issue.exc.inexactBit;
            excSetMask[`FSC_BIT_INV_HI:`FSC_BIT_INV_LO] = {
                issue.exc.compareInvalid,
                issue.exc.infTimesZeroInvalid,
                issue.exc.zeroByZeroInvalid,
                issue.exc.infByInfInvalid,
                issue.exc.infMinusInfInvalid,
                issue.exc.signalingNanInvalid};
        end
    end

    assign apbWrite = psel && penable && pwrite && apbHit;
    assign apbHit = (paddr == `FSC_ADDR_STATUS);

    // Software write first, hardware sets on top so a set is never lost
    always_comb begin
        next_status = statusStore;
        if (apbWrite) begin
            next_status = pwdata & `FSC_WRITABLE_MASK;
        end
        if (statusOp) begin
            next_status = next_status | excSetMask;
            if ((excSetMask & ~statusStore) != 32'h0) begin
                next_status[`FSC_BIT_ANY_SUM] = 1'b1;
            end
            next_status[`FSC_BIT_ROUNDED] = issue.roundedIndicator;
            next_status[`FSC_BIT_INEXACT_RES] = issue.inexactResultIndicator;
            next_status[`FSC_BIT_CLASS] = issue.resultClass;
            if (issue.op == FSC_OP_COMPARE) begin
                next_status[`FSC_BIT_CMP_HI:`FSC_BIT_CMP_LO] =
                    issue.compareFlags;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            statusStore <= `FSC_STATUS_RESET;
        end else if (ce) begin
            statusStore <= next_status;
        end
    end

    // Enable-masked view: each enable gates its own class
    always_comb begin
        excBits = statusStore;
        enabledBits = '0;
        enabledBits[`FSC_BIT_OVERFLOW] = statusStore[`FSC_BIT_OVF_EN];
        enabledBits[`FSC_BIT_UNDERFLOW] = statusStore[`FSC_BIT_UNF_EN];
        enabledBits[`FSC_BIT_ZERO_DIV] = statusStore[`FSC_BIT_ZDV_EN];
        enabledBits[`FSC_BIT_INEXACT] = statusStore[`FSC_BIT_INX_EN];
        for (int i = `FSC_BIT_INV_LO; i <= `FSC_BIT_INV_HI; i++) begin
            enabledBits[i] = statusStore[`FSC_BIT_INV_EN];
        end
    end

    assign anyEnabled = |(excBits & enabledBits);

    // Summary bits 1 and 2 read as derived values (the stored copy of bit 2 is never read); bit 0 is stored; reserved bits stay zero
    always_comb begin
        statusWord = statusStore & `FSC_WRITABLE_MASK;
        statusWord[`FSC_BIT_ENA_SUM] = anyEnabled;
        statusWord[`FSC_BIT_INV_SUM] =
            |statusStore[`FSC_BIT_INV_HI:`FSC_BIT_INV_LO];
    end

    assign roundMode = statusStore[`FSC_BIT_RND_HI:`FSC_BIT_RND_LO];

    // Register file writes: arithmetic results and loads
    always_ff @(posedge clk) begin
        if (runOp) begin
            unique case (issue.op)
                FSC_OP_ARITH, FSC_OP_ROUND_SINGLE: begin
                    floatReg[issue.target] <= issue.data;
                end
                FSC_OP_LOAD_DOUBLE: begin
                    floatReg[issue.target] <= issue.data;
                end
                FSC_OP_LOAD_SINGLE: begin
                    floatReg[issue.target] <= loadSingle;
                end
                FSC_OP_COMPARE, FSC_OP_STORE_DOUBLE,
                FSC_OP_STORE_SINGLE: begin
                end
            endcase
        end
    end

    // Operands, store data and completion
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            operandA <= '0;
            operandB <= '0;
            store <= '0;
            issueDone <= 1'b0;
            condField <= 4'h0;
        end else if (ce) begin
            issueDone <= runOp;
            store.valid <= 1'b0;
            if (runOp) begin
                operandA <= floatReg[issue.srcA];
                operandB <= floatReg[issue.srcB];
                if (issue.op == FSC_OP_STORE_DOUBLE) begin
                    store.valid <= 1'b1;
                    store.data <= floatReg[issue.srcA];
                end
                if (issue.op == FSC_OP_STORE_SINGLE) begin
                    store.valid <= 1'b1;
                    store.data <= {32'h0, storeSingle};
                end
                if (issue.op == FSC_OP_COMPARE) begin
                    condField <= issue.compareFlags;
                end
            end
        end
    end

    // Interrupt requests, one-cycle pulses
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            unavailableIrq <= 1'b0;
            programIrq <= 1'b0;
        end else if (ce) begin
            unavailableIrq <= take && !floatAvailable;
            programIrq <= statusOp && floatTrapEnable
                && ((excSetMask & enabledBits) != 32'h0);
        end
    end

    // APB: read data is captured in the setup cycle, answer in one access
    assign pready = psel && penable;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce && psel && !penable) begin
            prdata <= (apbHit && !pwrite) ? statusWord : 32'h0000_0000;
            pslverr <= !apbHit;
        end
    end
endmodule // fsc_unit
`default_nettype wire

// *** fsc_params.svh ***
// Offsets, field positions and reset values of the float status unit
`ifndef FSC_PARAMS_SVH
`define FSC_PARAMS_SVH
`define FSC_ADDR_STATUS 12'h000
`define FSC_STATUS_RESET 32'h0000_0000
`define FSC_BIT_ANY_SUM 0
`define FSC_BIT_ENA_SUM 1
`define FSC_BIT_INV_SUM 2
`define FSC_BIT_OVERFLOW 3
`define FSC_BIT_UNDERFLOW 4
`define FSC_BIT_ZERO_DIV 5
`define FSC_BIT_INEXACT 6
`define FSC_BIT_INV_LO 7
`define FSC_BIT_INV_HI 12
`define FSC_BIT_ROUNDED 13
`define FSC_BIT_INEXACT_RES 14
`define FSC_BIT_CLASS 15
`define FSC_BIT_CMP_LO 16
`define FSC_BIT_CMP_HI 19
`define FSC_BIT_INV_EN 24
`define FSC_BIT_OVF_EN 25
`define FSC_BIT_UNF_EN 26
`define FSC_BIT_ZDV_EN 27
`define FSC_BIT_INX_EN 28
`define FSC_BIT_RND_LO 30
`define FSC_BIT_RND_HI 31
`define FSC_WRITABLE_MASK 32'hDF0F_FFFD
`define FSC_SGL_BIAS_ADJ 11'h380
`define FSC_DBL_EXP_MAX 11'h7FF
`define FSC_SGL_EXP_MAX 8'hFF
`endif

// *** fsc_pkg.sv ***
// Types shared by the float status unit and its bench
`default_nettype none
package fsc_pkg;
    typedef enum logic [2:0] {
        FSC_OP_ARITH,
        FSC_OP_COMPARE,
        FSC_OP_ROUND_SINGLE,
        FSC_OP_LOAD_DOUBLE,
        FSC_OP_LOAD_SINGLE,
        FSC_OP_STORE_DOUBLE,
        FSC_OP_STORE_SINGLE
    } fsc_op_t;

    // Exception flags from the arithmetic datapath, one per status bit
    typedef struct packed {
        logic compareInvalid;
        logic infTimesZeroInvalid;
        logic zeroByZeroInvalid;
        logic infByInfInvalid;
        logic infMinusInfInvalid;
        logic signalingNanInvalid;
        logic inexactBit;
        logic zeroDivideBit;
        logic underflowBit;
        logic overflowBit;
    } fsc_exc_t;

    typedef struct packed {
        logic valid;
        fsc_op_t op;
        logic [4:0] target;
        logic [4:0] srcA;
        logic [4:0] srcB;
        logic [63:0] data;
        fsc_exc_t exc;
        logic roundedIndicator;
        logic inexactResultIndicator;
        logic resultClass;
        logic [3:0] compareFlags;
    } fsc_issue_t;

    typedef struct packed {
        logic valid;
        logic [63:0] data;
    } fsc_store_t;
endpackage
`default_nettype wire

// *** fsc_unit_assertions.sv ***
// Port-level checks of the float status unit
`default_nettype none
module fsc_unit_chk
    import fsc_pkg::*;
(
    // Clock
    input wire logic clk,
    input wire logic reset_n,
    // Issue
    input wire logic floatAvailable,
    input wire logic floatTrapEnable,
    input wire fsc_issue_t issue,
    // Results
    input wire logic issueDone,
    input wire logic [3:0] condField,
    input wire logic [1:0] roundMode,
    input wire logic unavailableIrq,
    input wire logic programIrq,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire logic acc = psel && penable;
    wire logic go = issue.valid && floatAvailable;
    chk_exec_done: assert property (go |=> issueDone)
        else $error("executed issue without done");
    chk_unavail_irq: assert property (
        issue.valid && !floatAvailable |=> unavailableIrq && !issueDone)
        else $error("unavailable issue not refused");
    chk_trap_gate: assert property (
        programIrq |-> $past(go && floatTrapEnable))
        else $error("program irq without trap enable");
    chk_cmp_flags: assert property (
        go && issue.op == FSC_OP_COMPARE
        |=> condField == $past(issue.compareFlags))
        else $error("compare flags lost");
    chk_round_wr: assert property (
        acc && pwrite && paddr == 12'h000
        |=> roundMode == $past(pwdata[31:30]))
        else $error("round mode not written");
    chk_rsvd_zero: assert property (
        acc |-> prdata[23:20] == 4'h0 && !prdata[29])
        else $error("reserved bit reads one");
    chk_inv_sum: assert property (acc |-> prdata[2] == |prdata[12:7])
        else $error("invalid summary wrong");
    chk_ena_sum: assert property (
        acc |-> prdata[1] == ((|prdata[12:7] & prdata[24])
        | |(prdata[6:3] & prdata[28:25])))
        else $error("enabled summary wrong");
    cover property (programIrq);
    cover property (unavailableIrq);
    cover property (acc && pwrite);
endmodule // fsc_unit_chk
bind fsc_unit fsc_unit_chk chk_i (.clk(clk), .reset_n(reset_n),
    .floatAvailable(floatAvailable), .floatTrapEnable(floatTrapEnable),
    .issue(issue), .issueDone(issueDone), .condField(condField),
    .roundMode(roundMode), .unavailableIrq(unavailableIrq),
    .programIrq(programIrq), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata));
`default_nettype wire

// *** fsc_dispatch_model.sv ***
// Dispatch-side model issuing float instructions
`default_nettype none
module fsc_dispatch_model
    import fsc_pkg::*;
(
    // Clock
    input wire logic clk,
    // Issue toward the unit
    output var fsc_issue_t issue
);
    timeunit 1ns;
    timeprecision 1ns;
    initial issue = '0;
    task automatic send(input fsc_op_t op, input logic [4:0] r,
        input logic [63:0] d, input fsc_exc_t e, input logic [3:0] cf,
        input logic [2:0] ri);
        fsc_issue_t t;
        t = '{valid: 1'b1, op: op, target: r, srcA: r, srcB: r, data: d,
            exc: e, roundedIndicator: ri[2], inexactResultIndicator: ri[1],
            resultClass: ri[0], compareFlags: cf};
        @(posedge clk);
        issue <= t;
        @(posedge clk);
        // Idle payload scrambled so stale fields are never trusted
        t = ~t;
        t.valid = 1'b0;
        issue <= t;
        #1;
    endtask
endmodule // fsc_dispatch_model
`default_nettype wire

// *** tb_fp_status_exception_control.sv ***
// Self-checking bench for the float status unit
`default_nettype none
module tb_fp_status_exception_control
    import fsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic floatAvailable = 1'b1;
    logic floatTrapEnable = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    fsc_issue_t issue;
    fsc_store_t store;
    logic issueDone, unavailableIrq, programIrq, pready, pslverr, re;
    logic [63:0] operandA, operandB;
    logic issueReady;
    logic [3:0] condField;
    logic [1:0] roundMode;
    logic [31:0] prdata, rq, sw;
    int bad_count = 0;
    int check_count = 0;
    int i;
    always #5 clk = ~clk;
    fsc_dispatch_model dsp (.clk(clk), .issue(issue));
    fsc_unit uut (.clk(clk), .reset_n(reset_n), .ce(1'b1),
        .floatAvailable(floatAvailable), .floatTrapEnable(floatTrapEnable),
        .issue(issue), .issueReady(issueReady), .issueDone(issueDone),
        .operandA(operandA), .operandB(operandB), .store(store),
        .condField(condField), .roundMode(roundMode),
        .unavailableIrq(unavailableIrq), .programIrq(programIrq),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [63:0] e,
        input logic [63:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rs(input logic [31:0] e);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk("status", 64'(e), 64'(rq));
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        bad_count++;
        report_and_stop;
    end
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        rs(32'h0000_0000);
        apb(1'b1, 12'h000, 32'hFFFF_FFFF);
        rs(32'hDF0F_FFFF);
        chk("roundMode", 64'h3, 64'(roundMode));
        apb(1'b1, 12'h004, 32'h0000_0000);
        chk("slverr", 64'h1, 64'(re));
        rs(32'hDF0F_FFFF);
        $display("register test done");
        dsp.send(FSC_OP_LOAD_DOUBLE, 5'h05, 64'h0123_4567_89AB_CDEF,
            '0, 4'h0, 3'h0);
        dsp.send(FSC_OP_LOAD_SINGLE, 5'h1F, 64'h5A5A_5A5A_C020_0000,
            '0, 4'h0, 3'h0);
        dsp.send(FSC_OP_STORE_DOUBLE, 5'h05, 64'h0, '0, 4'h0, 3'h0);
        chk("store double", 64'h0123_4567_89AB_CDEF, store.data);
        dsp.send(FSC_OP_STORE_SINGLE, 5'h1F, 64'h0, '0, 4'h0, 3'h0);
        chk("store single", 64'h0000_0000_C020_0000, store.data);
        chk("load single", 64'hC004_0000_0000_0000, operandA);
        chk("operandB", 64'hC004_0000_0000_0000, operandB);
        chk("issueReady", 64'h1, 64'(issueReady));
        $display("load store test done");
        apb(1'b1, 12'h000, 32'h0000_0000);
        sw = 32'h0000_0001;
        for (i = 0; i < 10; i++) begin
            dsp.send(FSC_OP_ARITH, 5'h07, 64'h0,
                fsc_exc_t'(10'h001 << i), 4'h0, 3'h0);
            sw = sw | (32'h0000_0008 << i) | (i > 3 ? 32'h4 : 32'h0);
            chk("done", 64'h1, 64'(issueDone));
            rs(sw);
        end
        apb(1'b1, 12'h000, 32'h0200_0000);
        floatTrapEnable <= 1'b1;
        dsp.send(FSC_OP_ARITH, 5'h07, 64'h0, 10'h001, 4'h0, 3'h0);
        chk("trap irq", 64'h1, 64'(programIrq));
        rs(32'h0200_000B);
        dsp.send(FSC_OP_ARITH, 5'h07, 64'h0, 10'h002, 4'h0, 3'h0);
        chk("masked irq", 64'h0, 64'(programIrq));
        @(posedge clk) floatTrapEnable <= 1'b0;
        apb(1'b1, 12'h000, 32'h0200_0000);
        dsp.send(FSC_OP_ARITH, 5'h07, 64'h0, 10'h001, 4'h0, 3'h0);
        chk("trap off", 64'h0, 64'(programIrq));
        $display("exception test done");
        @(posedge clk) floatAvailable <= 1'b0;
        apb(1'b1, 12'h000, 32'h0000_0000);
        dsp.send(FSC_OP_ARITH, 5'h07, 64'h0, 10'h001, 4'h0, 3'h0);
        chk("unavail irq", 64'h1, 64'(unavailableIrq));
        chk("no done", 64'h0, 64'(issueDone));
        rs(32'h0000_0000);
        @(posedge clk) floatAvailable <= 1'b1;
        dsp.send(FSC_OP_COMPARE, 5'h07, 64'h0, '0, 4'hA, 3'h0);
        chk("condField", 64'hA, 64'(condField));
        rs(32'h000A_0000);
        dsp.send(FSC_OP_ROUND_SINGLE, 5'h07, 64'h0, 10'h008, 4'h0, 3'h4);
        rs(32'h000A_2041);
        $display("status test done");
        report_and_stop;
    end
endmodule // tb_fp_status_exception_control
`default_nettype wire
